// ==== design/atp_pkg.sv ====
// constants and types for the task-file host port
// How it works
// - write-protect pin refuses destructive commands
// - refused command shows status 51h, error 04h
// - non-destructive commands run normally under protect
// - sleep pin mid-command: finish, then standby
// - standby ignores commands until hardware reset, pin released
// - data port 16-bit until set-features enables 8-bit
// - selects and three address lines pick registers
// - 8-bit data reads drive upper byte as zero
// - 16-bit data register moves buffer words
// - error register resets zero, bits 5,3,1 zero
// - bit 7 flags bad block or CRC
// - bit 6 uncorrectable, bit 4 sector not found
// - bit 2 aborted or invalid command
// - bit 0 general error
// - feature register write-only, parameters next command
// - sector count zero means 256 sectors
// - count zero on success, remainder on failure
// - sector and cylinder registers hold CHS or LBA
// - drive/head selects unit, head, LBA top bits
// - bit 6 picks LBA, bit 4 picks unit
// - status read clears interrupt, alternate does not
// - soft reset holds until cleared; irq disable bit
package atp_pkg;
    localparam logic [2:0] SEL_DATA = 3'h0;
    localparam logic [2:0] SEL_ERR_FEAT = 3'h1;
    localparam logic [2:0] SEL_COUNT = 3'h2;
    localparam logic [2:0] SEL_SECNUM = 3'h3;
    localparam logic [2:0] SEL_CYL_LO = 3'h4;
    localparam logic [2:0] SEL_CYL_HI = 3'h5;
    localparam logic [2:0] SEL_DRVHEAD = 3'h6;
    localparam logic [2:0] SEL_STAT_CMD = 3'h7;
    localparam logic [2:0] SEL_ALT_CTRL = 3'h6;
    localparam int DH_LBA = 6;
    localparam int DH_UNIT = 4;
    localparam int DC_SRST = 2;
    localparam int DC_NIEN = 1;
    localparam int PIN_MODE_PD = 0;
    localparam logic [7:0] ERR_RESET = 8'h00;
    localparam logic [7:0] ERR_ABORT = 8'h04;
    localparam logic [7:0] WP_STATUS = 8'h51;
    localparam logic [7:0] DEVCTL_RESET = 8'h08;
    localparam logic [7:0] DRVHEAD_RESET = 8'hA0;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [8:0] SECTORS_ZERO = 9'h100;
    localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
    localparam logic [7:0] CMD_SET_PIN_MODE = 8'h8B;
    localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
    localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
    typedef enum logic [1:0] {
        MD_IDLE = 2'h0,
        MD_BUSY = 2'h1,
        MD_STANDBY = 2'h3
    } atp_mode_t;
    function automatic logic atp_destructive(input logic [7:0] c);
        case (c)
            8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3C, 8'h50,
            8'hC0, 8'hC5, 8'hCA, 8'hCB, 8'hCD: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction : atp_destructive
endpackage : atp_pkg

// ==== design/atp_port.sv ====
// task-file host port with its write-data fifo
`timescale 1ns/1ps
`default_nettype none
module atp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic en_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } atp_fifo_st_t;
    atp_fifo_st_t s;
    atp_fifo_st_t next_s;
    logic push;
    logic take;
    logic [AW:0] used;
    // the output register counts toward the depth
    assign used = s.cnt + {{AW{1'b0}}, s.ov};
    always_comb
    begin
        next_s = s;
        push = in_valid_i && (used != FULL);
        take = (s.cnt != '0) && (!s.ov || out_ready_i);
        if (out_ready_i)
            next_s.ov = 1'b0;
        if (take)
        begin
            next_s.od = s.mem[s.rp];
            next_s.ov = 1'b1;
            next_s.rp = s.rp + 1'b1;
        end
        if (push)
        begin
            next_s.mem[s.wp] = in_data_i;
            next_s.wp = s.wp + 1'b1;
        end
        if (push && !take)
            next_s.cnt = s.cnt + 1'b1;
        else if (take && !push)
            next_s.cnt = s.cnt - 1'b1;
        if (!en_i)
            next_s = s;
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            s <= '0;
        else
            s <= next_s;
    end
    assign in_ready_o = (used != FULL);
    assign out_valid_o = s.ov;
    assign out_data_o = s.od;
endmodule : atp_fifo

module atp_port #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic hw_reset_n_i,
    input wire logic command_block_select_n_i,
    input wire logic control_block_select_n_i,
    input wire logic [2:0] register_select_lines_i,
    input wire logic host_read_strobe_n_i,
    input wire logic host_write_strobe_n_i,
    input wire logic [15:0] host_data_i,
    output logic [15:0] host_data_o,
    output logic [1:0] host_data_oe_n_o,
    output logic irq_o,
    input wire logic protect_or_sleep_pin_n_i,
    output logic cmd_start_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] feature_o,
    output logic [27:0] addr_o,
    output logic lba_mode_o,
    output logic unit_o,
    output logic [8:0] sectors_o,
    output logic core_reset_o,
    output logic standby_o,
    input wire logic core_ready_i,
    input wire logic core_done_i,
    input wire logic [4:0] core_err_i,
    input wire logic core_fault_i,
    input wire logic core_corr_i,
    input wire logic [7:0] core_remain_i,
    input wire logic core_drq_i,
    input wire logic [15:0] rd_word_i,
    output logic rd_pop_o,
    output logic [15:0] wr_data_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i
);
    typedef struct packed {
        logic rd_q;
        logic wr_q;
        logic [2:0] sel;
        logic cmd_cs;
        logic ctl_cs;
        logic [15:0] din;
        logic [7:0] feature;
        logic [7:0] count;
        logic [8:0] total;
        logic [7:0] secnum;
        logic [7:0] cyl_lo;
        logic [7:0] cyl_hi;
        logic [7:0] drvhead;
        logic [7:0] error;
        logic [7:0] devctl;
        logic [7:0] command;
        atp_pkg::atp_mode_t mode;
        logic in_cmd;
        logic dwf;
        logic corr;
        logic err;
        logic irq_pend;
        logic pd_mode;
        logic pd_pend;
        logic byte8;
        logic phase;
        logic [7:0] low_byte;
        logic [15:0] dout;
        logic [1:0] oe_n;
        logic irq;
        logic cmd_start;
        logic [15:0] wr_word;
        logic wr_push;
        logic rd_pop;
        logic core_rst;
    } atp_state_t;
    atp_state_t s;
    atp_state_t next_s;
    logic fifo_ready;
    logic [7:0] stat;
    logic cmd_now;
    logic ctl_now;
    logic rd_end;
    logic wr_end;
    logic tf_reset;
    logic wp_active;
    // selects decoded from chip selects and address lines only
    assign cmd_now = !command_block_select_n_i
        && control_block_select_n_i;
    assign ctl_now = !control_block_select_n_i && command_block_select_n_i
        && (register_select_lines_i == atp_pkg::SEL_ALT_CTRL);
    assign rd_end = s.rd_q && host_read_strobe_n_i;
    assign wr_end = s.wr_q && host_write_strobe_n_i;
    assign tf_reset = !hw_reset_n_i || s.devctl[atp_pkg::DC_SRST];
    assign wp_active = !s.pd_mode && !protect_or_sleep_pin_n_i;
    // status byte; the other bits stay visible to the host while busy is set
    assign stat = {s.mode == atp_pkg::MD_BUSY, core_ready_i, s.dwf,
        core_ready_i, core_drq_i && fifo_ready, s.corr, 1'b0, s.err};
    always_comb
    begin
        next_s = s;
        next_s.cmd_start = 1'b0;
        next_s.wr_push = 1'b0;
        next_s.rd_pop = 1'b0;
        next_s.rd_q = !host_read_strobe_n_i && (cmd_now || ctl_now);
        next_s.wr_q = !host_write_strobe_n_i && (cmd_now || ctl_now);
        if (next_s.rd_q || next_s.wr_q)
        begin
            next_s.sel = register_select_lines_i;
            next_s.cmd_cs = cmd_now;
            next_s.ctl_cs = ctl_now;
            next_s.din = host_data_i;
        end
        // read data launched while the strobe is low
        next_s.oe_n = 2'h3;
        next_s.dout = 16'h0000;
        if (!host_read_strobe_n_i && cmd_now)
        begin
            next_s.oe_n = 2'h2;
            case (register_select_lines_i)
                atp_pkg::SEL_DATA:
                begin
                    next_s.oe_n = 2'h0;
                    next_s.dout = rd_word_i;
                    if (s.byte8)
                    begin
                        next_s.dout = {atp_pkg::ZERO_BYTE, s.phase ?
                            rd_word_i[15:8] : rd_word_i[7:0]};
                    end
                end
                atp_pkg::SEL_ERR_FEAT: next_s.dout[7:0] = s.error;
                atp_pkg::SEL_COUNT: next_s.dout[7:0] = s.count;
                atp_pkg::SEL_SECNUM: next_s.dout[7:0] = s.secnum;
                atp_pkg::SEL_CYL_LO: next_s.dout[7:0] = s.cyl_lo;
                atp_pkg::SEL_CYL_HI: next_s.dout[7:0] = s.cyl_hi;
                atp_pkg::SEL_DRVHEAD: next_s.dout[7:0] = s.drvhead;
                default: next_s.dout[7:0] = stat;
            endcase
        end
        else if (!host_read_strobe_n_i && ctl_now)
        begin
            next_s.oe_n = 2'h2;
            next_s.dout[7:0] = stat;
        end
        // read side effects at the strobe's trailing edge
        if (rd_end && s.cmd_cs && s.sel == atp_pkg::SEL_STAT_CMD)
        begin
            next_s.irq_pend = 1'b0;
        end
        if (rd_end && s.cmd_cs && s.sel == atp_pkg::SEL_DATA)
        begin
            next_s.phase = s.byte8 && !s.phase;
            next_s.rd_pop = !s.byte8 || s.phase;
        end
        if (tf_reset)
        begin
            next_s.mode = (s.mode == atp_pkg::MD_STANDBY && !(!hw_reset_n_i
                && protect_or_sleep_pin_n_i)) ? atp_pkg::MD_STANDBY
                : atp_pkg::MD_BUSY;
            next_s.error = atp_pkg::ERR_RESET;
            next_s.drvhead = atp_pkg::DRVHEAD_RESET;
            next_s.count = atp_pkg::ZERO_BYTE;
            next_s.secnum = atp_pkg::ZERO_BYTE;
            next_s.cyl_lo = atp_pkg::ZERO_BYTE;
            next_s.cyl_hi = atp_pkg::ZERO_BYTE;
            next_s.err = 1'b0;
            next_s.dwf = 1'b0;
            next_s.corr = 1'b0;
            next_s.irq_pend = 1'b0;
            next_s.in_cmd = 1'b0;
            next_s.pd_pend = 1'b0;
            next_s.byte8 = 1'b0;
            next_s.phase = 1'b0;
        end
        else
        begin
            if (wr_end && s.cmd_cs)
            begin
                case (s.sel)
                    atp_pkg::SEL_DATA:
                    begin
                        if (s.byte8 && !s.phase)
                        begin
                            next_s.low_byte = s.din[7:0];
                            next_s.phase = 1'b1;
                        end
                        else if (fifo_ready)
                        begin
                            next_s.wr_word = s.byte8 ? {s.din[7:0],
                                s.low_byte} : s.din;
                            next_s.wr_push = 1'b1;
                            next_s.phase = 1'b0;
                        end
                    end
                    atp_pkg::SEL_ERR_FEAT: next_s.feature = s.din[7:0];
                    atp_pkg::SEL_COUNT: next_s.count = s.din[7:0];
                    atp_pkg::SEL_SECNUM: next_s.secnum = s.din[7:0];
                    atp_pkg::SEL_CYL_LO: next_s.cyl_lo = s.din[7:0];
                    atp_pkg::SEL_CYL_HI: next_s.cyl_hi = s.din[7:0];
                    atp_pkg::SEL_DRVHEAD: next_s.drvhead = s.din[7:0];
                    default:
                    begin
                        if (s.mode == atp_pkg::MD_IDLE)
                        begin
                            next_s.command = s.din[7:0];
                            next_s.error = atp_pkg::ERR_RESET;
                            next_s.err = 1'b0;
                            next_s.corr = 1'b0;
                            next_s.dwf = 1'b0;
                            next_s.phase = 1'b0;
                            if (wp_active && atp_pkg::atp_destructive(
                                s.din[7:0]))
                            begin
                                next_s.error = atp_pkg::ERR_ABORT;
                                next_s.err = 1'b1;
                                next_s.irq_pend = 1'b1;
                            end
                            else if (s.din[7:0] == atp_pkg::CMD_SET_FEATURES
                                && (s.feature == atp_pkg::FEAT_8BIT_ON ||
                                s.feature == atp_pkg::FEAT_8BIT_OFF))
                            begin
                                next_s.byte8 = (s.feature ==
                                    atp_pkg::FEAT_8BIT_ON);
                                next_s.irq_pend = 1'b1;
                            end
                            else if (s.din[7:0] == atp_pkg::CMD_SET_PIN_MODE)
                            begin
                                next_s.pd_mode =
                                    s.feature[atp_pkg::PIN_MODE_PD];
                                next_s.irq_pend = 1'b1;
                            end
                            else
                            begin
                                next_s.mode = atp_pkg::MD_BUSY;
                                next_s.in_cmd = 1'b1;
                                next_s.cmd_start = 1'b1;
                            end
                        end
                    end
                endcase
            end
            if (s.mode == atp_pkg::MD_BUSY && s.in_cmd && s.pd_mode
                && !protect_or_sleep_pin_n_i)
            begin
                next_s.pd_pend = 1'b1;
            end
            if (s.mode == atp_pkg::MD_BUSY && core_done_i)
            begin
                next_s.mode = (next_s.pd_pend && s.in_cmd) ?
                    atp_pkg::MD_STANDBY : atp_pkg::MD_IDLE;
                next_s.pd_pend = 1'b0;
                if (s.in_cmd)
                begin
                    next_s.error = {core_err_i[4], core_err_i[3], 1'b0,
                        core_err_i[2], 1'b0, core_err_i[1], 1'b0,
                        core_err_i[0]};
                    next_s.err = |core_err_i || core_fault_i;
                    next_s.dwf = core_fault_i;
                    next_s.corr = core_corr_i;
                    next_s.count = core_remain_i;
                    next_s.irq_pend = 1'b1;
                end
                next_s.in_cmd = 1'b0;
            end
        end
        if (wr_end && s.ctl_cs)
        begin
            next_s.devctl = s.din[7:0];
        end
        if (!hw_reset_n_i)
        begin
            next_s.devctl = atp_pkg::DEVCTL_RESET;
        end
        next_s.total = (next_s.count == atp_pkg::ZERO_BYTE) ?
            atp_pkg::SECTORS_ZERO : {1'b0, next_s.count};
        next_s.irq = next_s.irq_pend && !next_s.devctl[atp_pkg::DC_NIEN];
        next_s.core_rst = !hw_reset_n_i || next_s.devctl[atp_pkg::DC_SRST];
        if (!clk_en_i)
        begin
            next_s = s;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            s <= '0;
            s.oe_n <= 2'h3;
            s.mode <= atp_pkg::MD_BUSY;
            s.devctl <= atp_pkg::DEVCTL_RESET;
            s.drvhead <= atp_pkg::DRVHEAD_RESET;
            s.total <= atp_pkg::SECTORS_ZERO;
        end
        else
        begin
            s <= next_s;
        end
    end
    atp_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .en_i(clk_en_i),
        .in_valid_i(s.wr_push),
        .in_data_i(s.wr_word),
        .in_ready_o(fifo_ready),
        .out_valid_o(wr_valid_o),
        .out_data_o(wr_data_o),
        .out_ready_i(wr_ready_i)
    );
    assign host_data_o = s.dout;
    assign host_data_oe_n_o = s.oe_n;
    assign irq_o = s.irq;
    assign cmd_start_o = s.cmd_start;
    assign cmd_code_o = s.command;
    assign feature_o = s.feature;
    assign addr_o = {s.drvhead[3:0], s.cyl_hi, s.cyl_lo, s.secnum};
    assign lba_mode_o = s.drvhead[atp_pkg::DH_LBA];
    assign unit_o = s.drvhead[atp_pkg::DH_UNIT];
    assign sectors_o = s.total;
    assign core_reset_o = s.core_rst;
    assign standby_o = s.mode == atp_pkg::MD_STANDBY;
    assign rd_pop_o = s.rd_pop;
    logic cmd_evt;
    assign cmd_evt = clk_en_i && wr_end && s.cmd_cs && !tf_reset
        && s.sel == atp_pkg::SEL_STAT_CMD;
    default clocking cb_asrt @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence seq_pd_done;
        s.mode == atp_pkg::MD_BUSY && s.in_cmd && s.pd_mode
            && !protect_or_sleep_pin_n_i && core_done_i && clk_en_i
            && !tf_reset;
    endsequence
    sequence seq_cs_invalid;
        !command_block_select_n_i && !control_block_select_n_i
            && clk_en_i;
    endsequence
    AST_WP_REFUSE: assert property (
        cmd_evt && s.mode == atp_pkg::MD_IDLE && wp_active
            && atp_pkg::atp_destructive(s.din[7:0])
        |=> s.error == atp_pkg::ERR_ABORT && s.err && !s.cmd_start
            && s.mode == atp_pkg::MD_IDLE)
        else $error("destructive command not refused");
    AST_NONDESTR_RUNS: assert property (
        cmd_evt && s.mode == atp_pkg::MD_IDLE
            && !atp_pkg::atp_destructive(s.din[7:0])
            && s.din[7:0] != atp_pkg::CMD_SET_FEATURES
            && s.din[7:0] != atp_pkg::CMD_SET_PIN_MODE
        |=> cmd_start_o && s.mode == atp_pkg::MD_BUSY ##1 !cmd_start_o)
        else $error("command not started");
    AST_PD_STANDBY: assert property (
        seq_pd_done |=> standby_o)
        else $error("no standby after sleep pin");
    AST_STANDBY_IGNORES: assert property (
        standby_o && cmd_evt |=> !cmd_start_o && standby_o)
        else $error("command accepted in standby");
    AST_BYTE8_RESET: assert property (
        !hw_reset_n_i && clk_en_i |=> !s.byte8 && !s.irq_pend)
        else $error("8-bit mode survived reset");
    AST_INVALID_CS: assert property (
        seq_cs_invalid ##1 seq_cs_invalid |-> host_data_oe_n_o == 2'h3)
        else $error("bus driven with both selects");
    AST_ERR_ZERO_BITS: assert property (
        !s.error[5] && !s.error[3] && !s.error[1])
        else $error("reserved error bit set");
    AST_STATUS_CLR_IRQ: assert property (
        clk_en_i && rd_end && s.cmd_cs && s.sel == atp_pkg::SEL_STAT_CMD
            && !core_done_i && !wr_end
        |=> !s.irq_pend ##1 !irq_o)
        else $error("status read left interrupt pending");
    AST_SRST_HOLDS: assert property (
        s.devctl[atp_pkg::DC_SRST] && clk_en_i && !(wr_end && s.ctl_cs)
            |=> core_reset_o && (standby_o || s.mode == atp_pkg::MD_BUSY))
        else $error("soft reset not held");
    AST_ZERO_256: assert property (
        s.count == atp_pkg::ZERO_BYTE |-> sectors_o == atp_pkg::SECTORS_ZERO)
        else $error("zero count not 256");
endmodule : atp_port
`default_nettype wire

// ==== verification/ata_task_file_host_port_tb.sv ====
// self-checking bench for the task-file host port
`timescale 1ns/1ps
`default_nettype none
module ata_task_file_host_port_tb;
    logic clk = 1'b0, rst_b = 1'b0, hw_n = 1'b1, c0 = 1'b1, c1 = 1'b1;
    logic rd_n = 1'b1, wr_n = 1'b1, pin_n = 1'b1, stall = 1'b0;
    logic [2:0] a = 3'h0;
    logic [15:0] dq = 16'h0000, rw, q, w;
    logic [4:0] ecfg = 5'h00;
    logic [7:0] v, s, cl, ch, dh;
    wire logic [15:0] dout, wdat, last;
    wire logic [1:0] oe_n;
    wire logic irq, start, lba, unit, crst, stby, done, wrdy, wval, pop;
    wire logic [7:0] code, feat, rem;
    wire logic [27:0] addr;
    wire logic [8:0] secs;
    wire logic [4:0] cerr;
    wire logic [3:0] got;
    int error_cnt = 0, checks_done = 0, seed = 39485, cyc = 0, ns = 0, n0, i, k;
    logic [7:0] dc [12] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h3C,
        8'h50, 8'hC0, 8'hC5, 8'hCA, 8'hCB, 8'hCD};
    always #5 clk = !clk;
    atp_port dut_u (.sys_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
        .hw_reset_n_i(hw_n), .command_block_select_n_i(c0),
        .control_block_select_n_i(c1), .register_select_lines_i(a),
        .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n),
        .host_data_i(dq), .host_data_o(dout), .host_data_oe_n_o(oe_n),
        .irq_o(irq), .protect_or_sleep_pin_n_i(pin_n), .cmd_start_o(start),
        .cmd_code_o(code), .feature_o(feat), .addr_o(addr), .lba_mode_o(lba),
        .unit_o(unit), .sectors_o(secs), .core_reset_o(crst),
        .standby_o(stby), .core_ready_i(1'b1), .core_done_i(done),
        .core_err_i(cerr), .core_fault_i(1'b0), .core_corr_i(1'b0),
        .core_remain_i(rem), .core_drq_i(1'b0), .rd_word_i(rw),
        .rd_pop_o(pop), .wr_data_o(wdat), .wr_valid_o(wval),
        .wr_ready_i(wrdy));
    atp_core_model core_u (.sys_clk_i(clk), .rst_b_i(rst_b),
        .cmd_start_i(start), .core_reset_i(crst), .err_cfg_i(ecfg),
        .stall_i(stall), .wr_valid_i(wval), .wr_data_i(wdat),
        .core_done_o(done), .core_err_o(cerr), .remain_o(rem),
        .wr_ready_o(wrdy), .got_o(got), .last_o(last));
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (start === 1'b1)
            ns <= ns + 1;
        if (cyc == 40000)
        begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end
    function automatic logic [8:0] sec_exp(input logic [7:0] c);
        return (c == 8'h00) ? 9'h100 : {1'b0, c};
    endfunction : sec_exp
    function automatic logic [7:0] err_exp(input logic [4:0] e);
        return {e[4], e[3], 1'b0, e[2], 1'b0, e[1], 1'b0, e[0]};
    endfunction : err_exp
    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // one host cycle: two low cycles, read data sampled on the second
    task automatic acc(input logic we, input logic ctl, input logic [2:0] ad,
        input logic [15:0] d);
        @(posedge clk);
        #1;
        c0 = ctl;
        c1 = !ctl;
        a = ad;
        dq = d;
        rd_n = we;
        wr_n = !we;
        repeat (2) @(posedge clk);
        #1;
        q = dout;
        rd_n = 1'b1;
        wr_n = 1'b1;
        c0 = 1'b1;
        c1 = 1'b1;
        @(posedge clk) #1;
    endtask : acc
    task automatic idle();
        for (k = 0; k < 60; k++)
        begin
            acc(1'b0, 1'b1, 3'h6, 16'h0000);
            if (q[7] === 1'b0)
                break;
        end
        if (k == 60)
            chk(q[7], 1'b0);
    endtask : idle
    task automatic cmd(input logic [7:0] c);
        acc(1'b1, 1'b0, 3'h7, {8'h00, c});
        idle();
    endtask : cmd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial
    begin
        rw = $random(seed);
        repeat (20) @(posedge clk);
        #1 rst_b = 1'b1;
        idle();
        acc(1'b0, 1'b0, 3'h1, 16'h0000);
        chk(q[7:0], 8'h00);
        acc(1'b0, 1'b0, 3'h6, 16'h0000);
        chk(q[7:0], 8'hA0);
        $display("reset test done");
        for (i = 0; i < 5; i++)
        begin
            v = (i == 0) ? 8'h00 : $random(seed);
            s = $random(seed);
            cl = $random(seed);
            ch = $random(seed);
            dh = $random(seed) | 8'hA0;
            acc(1'b1, 1'b0, 3'h2, {$random(seed), v});
            acc(1'b1, 1'b0, 3'h3, {8'h00, s});
            acc(1'b1, 1'b0, 3'h4, {8'h00, cl});
            acc(1'b1, 1'b0, 3'h5, {8'h00, ch});
            acc(1'b1, 1'b0, 3'h6, {8'h00, dh});
            chk(addr, {dh[3:0], ch, cl, s});
            chk({secs, lba, unit}, {sec_exp(v), dh[6], dh[4]});
            acc(1'b0, 1'b0, 3'h4, 16'h0000);
            chk({oe_n, q[7:0]}, {2'b11, cl});
        end
        $display("address test done");
        for (i = 0; i < 6; i++)
        begin
            ecfg = (i == 5) ? 5'h00 : (5'h01 << i);
            repeat (2) cmd(8'h20);
            acc(1'b0, 1'b0, 3'h1, 16'h0000);
            chk(q[7:0], err_exp(ecfg));
            acc(1'b0, 1'b0, 3'h2, 16'h0000);
            chk(q[7:0], (i == 5) ? 8'h00 : 8'h05);
            chk(irq, 1'b1);
            acc(1'b0, 1'b0, 3'h7, 16'h0000);
            chk(q[0], (i != 5));
            @(posedge clk);
            #1 chk(irq, 1'b0);
        end
        $display("error test done");
        pin_n = 1'b0;
        n0 = ns;
        for (i = 0; i < 12; i++)
        begin
            cmd(dc[i]);
            acc(1'b0, 1'b0, 3'h7, 16'h0000);
            chk(q[7:0], 8'h51);
            acc(1'b0, 1'b0, 3'h1, 16'h0000);
            chk(q[7:0], 8'h04);
        end
        chk(ns, n0);
        cmd(8'h20);
        acc(1'b0, 1'b0, 3'h1, 16'h0000);
        chk({code, 12'(ns - n0), q[7:0]}, {8'h20, 12'h001, 8'h00});
        pin_n = 1'b1;
        @(posedge clk);
        #1 {c0, c1, rd_n} = 3'b000;
        repeat (3) @(posedge clk);
        #1 chk(oe_n, 2'b11);
        {c0, c1, rd_n} = 3'b111;
        acc(1'b1, 1'b0, 3'h1, 16'h005A);
        acc(1'b0, 1'b0, 3'h1, 16'h0000);
        chk({feat, q[7:0]}, {8'h5A, 8'h00});
        $display("protect test done");
        stall = 1'b1;
        for (i = 0; i < 9; i++)
        begin
            w = (i == 7) ? $random(seed) : w;
            acc(1'b1, 1'b0, 3'h0, (i == 7) ? w : $random(seed));
        end
        stall = 1'b0;
        repeat (20) @(posedge clk);
        chk({got, last}, {4'h8, w});
        acc(1'b1, 1'b0, 3'h1, 16'h0001);
        cmd(8'hEF);
        acc(1'b1, 1'b0, 3'h0, 16'hA534);
        acc(1'b1, 1'b0, 3'h0, 16'h5A12);
        repeat (6) @(posedge clk);
        chk({got, last}, {4'h9, 16'h1234});
        repeat (2) acc(1'b0, 1'b0, 3'h0, 16'h0000);
        chk({pop, q}, {1'b1, 8'h00, rw[15:8]});
        acc(1'b1, 1'b0, 3'h1, 16'h0081);
        cmd(8'hEF);
        $display("data test done");
        acc(1'b1, 1'b0, 3'h1, 16'h0001);
        cmd(8'h8B);
        acc(1'b1, 1'b0, 3'h7, 16'h0020);
        pin_n = 1'b0;
        repeat (12) @(posedge clk);
        chk(stby, 1'b1);
        n0 = ns;
        acc(1'b1, 1'b0, 3'h7, 16'h0020);
        repeat (12) @(posedge clk);
        chk(ns, n0);
        #1 pin_n = 1'b1;
        hw_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 hw_n = 1'b1;
        idle();
        chk(stby, 1'b0);
        $display("sleep test done");
        complete_run();
    end
endmodule : ata_task_file_host_port_tb
`default_nettype wire

// ==== verification/atp_core_model.sv ====
// behavioural media core on the far side of the task-file port
`timescale 1ns/1ps
`default_nettype none
module atp_core_model (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_start_i,
    input wire logic core_reset_i,
    input wire logic [4:0] err_cfg_i,
    input wire logic stall_i,
    input wire logic wr_valid_i,
    input wire logic [15:0] wr_data_i,
    output logic core_done_o,
    output logic [4:0] core_err_o,
    output logic [7:0] remain_o,
    output logic wr_ready_o,
    output logic [3:0] got_o,
    output logic [15:0] last_o
);
    logic [2:0] pend;
    assign core_done_o = (pend == 3'h1);
    assign core_err_o = core_done_o ? err_cfg_i : 5'h1F;
    assign remain_o = core_done_o ? {7'h00, |err_cfg_i} * 8'h05 : 8'hFF;
    assign wr_ready_o = !stall_i;
    always_ff @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pend <= 3'h4;
            got_o <= 4'h0;
            last_o <= 16'h0000;
        end
        else
        begin
            if (core_reset_i || cmd_start_i)
                pend <= 3'h4;
            else if (pend != 3'h0)
                pend <= pend - 3'h1;
            if (wr_valid_i && wr_ready_o)
            begin
                got_o <= got_o + 4'h1;
                last_o <= wr_data_i;
            end
        end
    end
endmodule : atp_core_model
`default_nettype wire
